// >>> common/led_consts.svh
`ifndef LED_CONSTS_SVH
`define LED_CONSTS_SVH
`define ADDR_CONFIG      7'h10
`define ADDR_RAMP_DOWN   7'h11
`define ADDR_RAMP_UP     7'h12
`define ADDR_SEL_LOW     7'h13
`define ADDR_SEL_HIGH    7'h14
`define ADDR_GLOBAL      7'h15
`define RST_SEL_LOW      8'h00
`define RST_SEL_HIGH     2'h0
`define RST_GLOBAL       3'h7
`define RST_CODE         3'h0
`define SCALE_FULL       3'h7
`define SCALE_ZERO       3'h0
`define CFG_RUN_BIT      0
`define CFG_HOLD_BIT     3
`define CFG_FADE_BIT     4
`define CFG_RAMP_BIT     5
`define FRAME_BITS       5'h10
`define ADDR_BITS_DONE   5'h08
`define PWM_TICK_HZ      32768
`define SHORTEST_DIV     16
`define FADE_STEPS       8
`define BASE_TICKS       (`PWM_TICK_HZ / `SHORTEST_DIV)
`define STEP_BASE_TICKS  (`BASE_TICKS / `FADE_STEPS)
`endif

// >>> common/led_pkg.sv
package led_pkg;
    typedef enum logic [4:0] {
        ST_RUN  = 5'h01,
        ST_HOLD = 5'h02,
        ST_FADE = 5'h04,
        ST_SHDN = 5'h08,
        ST_RAMP = 5'h10
    } ramp_state_t;
    typedef logic [17:0] tick_cnt_t;
endpackage

// >>> rtl/serial_reg_port.sv
`timescale 1ns/1ns
`include "led_consts.svh"
// 16-bit frame: D15 read flag, D14-D8 address, D7-D0 data, MSB first
module serial_reg_port
    import led_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic       din,
    input  wire logic [7:0] rdata,
    output logic            dout,
    output logic            wr_stb,
    output logic [6:0]      addr,
    output logic [7:0]      wdata
);
    logic [15:0] shift_r, shift_nxt;
    logic [4:0]  cnt_r, cnt_nxt;
    logic [7:0]  out_r, out_nxt;
    logic        sclk_r, sclk_nxt;
    logic        cs_n_r, cs_n_nxt;
    logic        stb_r, stb_nxt;

    // shift in on sclk rise, shift read data out on sclk fall
    always_comb begin
        shift_nxt = shift_r;
        cnt_nxt   = cnt_r;
        out_nxt   = out_r;
        sclk_nxt  = sclk;
        cs_n_nxt  = cs_n;
        stb_nxt   = 1'b0;
        if (cs_n) begin
            cnt_nxt = 5'h00;
            // commit only a whole write frame, at the end of the frame
            if (!cs_n_r && cnt_r == `FRAME_BITS && !shift_r[15]) begin
                stb_nxt = 1'b1;
            end
        end else if (sclk && !sclk_r) begin
            shift_nxt = {shift_r[14:0], din};
            if (cnt_r != 5'h1F) begin
                cnt_nxt = cnt_r + 5'h01;
            end
            if (cnt_r == `ADDR_BITS_DONE - 5'h01) begin
                out_nxt = rdata;
            end
        end else if (!sclk && sclk_r && cnt_r > `ADDR_BITS_DONE) begin
            out_nxt = {out_r[6:0], 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            shift_r <= 16'h0000;
            cnt_r   <= 5'h00;
            out_r   <= 8'h00;
            sclk_r  <= 1'b0;
            cs_n_r  <= 1'b1;
            stb_r   <= 1'b0;
        end else begin
            shift_r <= shift_nxt;
            cnt_r   <= cnt_nxt;
            out_r   <= out_nxt;
            sclk_r  <= sclk_nxt;
            cs_n_r  <= cs_n_nxt;
            stb_r   <= stb_nxt;
        end
    end

    // read address is valid at the eighth bit's rise, and again once all 16 bits are in
    assign addr   = (cnt_r == `ADDR_BITS_DONE - 5'h01 && !cs_n && sclk
                     && !sclk_r) ? {shift_r[5:0], din} : shift_r[14:8];
    assign wdata  = shift_r[7:0];
    assign wr_stb = stb_r;
    assign dout   = out_r[7];
endmodule

// >>> rtl/led_current_select_regs.sv
`timescale 1ns/1ns
`include "led_consts.svh"
module led_current_select_regs
    import led_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        RST,
    input  wire logic        CS_N,
    input  wire logic        SCLK,
    input  wire logic        DIN,
    input  wire logic        PWM_TICK,
    output logic             DOUT,
    output logic [39:0]      PORT_CTRL,
    output logic [2:0]       FADE_SCALE,
    output logic             SHUTDOWN
);
    logic        wr_stb;
    logic [6:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        dout_i;

    serial_reg_port u_port (
        .clk    (MCLK),
        .rst    (RST),
        .cs_n   (CS_N),
        .sclk   (SCLK),
        .din    (DIN),
        .rdata  (rdata),
        .dout   (dout_i),
        .wr_stb (wr_stb),
        .addr   (addr),
        .wdata  (wdata)
    );
    assign DOUT = dout_i;

    logic [7:0]  port_select_bits_low_r, port_select_bits_low_nxt;
    logic [1:0]  port_select_bits_high_r, port_select_bits_high_nxt;
    logic [2:0]  global_r, global_nxt;
    logic [2:0]  hold_code_r, hold_code_nxt;
    logic [2:0]  fade_code_r, fade_code_nxt;
    logic [2:0]  rise_code_r, rise_code_nxt;
    ramp_state_t state_r, state_nxt;
    tick_cnt_t   tmr_r, tmr_nxt;
    logic [2:0]  scale_r, scale_nxt;
    logic        down_req, up_req;

    // ticks for a code: zero for 000, base doubling per step above
    function automatic tick_cnt_t dur(input logic [2:0] code,
                                      input int        base);
        tick_cnt_t d;
        d = '0;
        if (code != 3'h0) begin
            // integer base narrowed once to the timer width
            d = tick_cnt_t'(base) << (code - 3'h1);
        end
        return d;
    endfunction

    // register writes from the serial port
    always_comb begin
        port_select_bits_low_nxt  = port_select_bits_low_r;
        port_select_bits_high_nxt = port_select_bits_high_r;
        global_nxt    = global_r;
        hold_code_nxt = hold_code_r;
        fade_code_nxt = fade_code_r;
        rise_code_nxt = rise_code_r;
        if (wr_stb) begin
            case (addr)
                `ADDR_SEL_LOW:   port_select_bits_low_nxt = wdata;
                `ADDR_SEL_HIGH:  port_select_bits_high_nxt = wdata[1:0];
                `ADDR_GLOBAL:    global_nxt = wdata[2:0];
                `ADDR_RAMP_DOWN: begin
                    hold_code_nxt = wdata[5:3];
                    fade_code_nxt = wdata[2:0];
                end
                `ADDR_RAMP_UP:   rise_code_nxt = wdata[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            port_select_bits_low_r  <= `RST_SEL_LOW;
            port_select_bits_high_r <= `RST_SEL_HIGH;
            global_r    <= `RST_GLOBAL;
            hold_code_r <= `RST_CODE;
            fade_code_r <= `RST_CODE;
            rise_code_r <= `RST_CODE;
        end else begin
            port_select_bits_low_r  <= port_select_bits_low_nxt;
            port_select_bits_high_r <= port_select_bits_high_nxt;
            global_r    <= global_nxt;
            hold_code_r <= hold_code_nxt;
            fade_code_r <= fade_code_nxt;
            rise_code_r <= rise_code_nxt;
        end
    end

    // config writes: run bit low starts ramp-down, high wakes up
    assign down_req = wr_stb && addr == `ADDR_CONFIG
                      && !wdata[`CFG_RUN_BIT] && state_r == ST_RUN;
    assign up_req   = wr_stb && addr == `ADDR_CONFIG
                      && wdata[`CFG_RUN_BIT] && state_r == ST_SHDN;

    // read mux, unused bits read zero
    always_comb begin
        rdata = 8'h00;
        case (addr)
            `ADDR_SEL_LOW:   rdata = port_select_bits_low_r;
            `ADDR_SEL_HIGH:  rdata = {6'h00, port_select_bits_high_r};
            `ADDR_GLOBAL:    rdata = {5'h00, global_r};
            `ADDR_RAMP_DOWN: rdata = {2'h0, hold_code_r, fade_code_r};
            `ADDR_RAMP_UP:   rdata = {5'h00, rise_code_r};
            `ADDR_CONFIG: begin
                rdata[`CFG_RUN_BIT]  = state_r != ST_SHDN;
                rdata[`CFG_HOLD_BIT] = state_r == ST_HOLD;
                rdata[`CFG_FADE_BIT] = state_r == ST_FADE;
                rdata[`CFG_RAMP_BIT] = state_r == ST_RAMP;
            end
            default: rdata = 8'h00;
        endcase
    end

    // ramp sequencer, timed by the PWM tick
    always_comb begin
        state_nxt = state_r;
        tmr_nxt   = tmr_r;
        scale_nxt = scale_r;
        case (state_r)
            ST_RUN: begin
                scale_nxt = `SCALE_FULL;
                if (down_req) begin
                    state_nxt = ST_HOLD;
                    tmr_nxt   = dur(hold_code_r, `BASE_TICKS);
                end
            end
            ST_HOLD: begin
                if (tmr_r == '0) begin
                    state_nxt = ST_FADE;
                    tmr_nxt   = dur(fade_code_r, `STEP_BASE_TICKS);
                    if (fade_code_r == 3'h0) begin
                        state_nxt = ST_SHDN;
                        scale_nxt = `SCALE_ZERO;
                    end
                end else if (PWM_TICK) begin
                    tmr_nxt = tmr_r - 18'h1;
                end
            end
            ST_FADE: begin
                if (PWM_TICK) begin
                    tmr_nxt = tmr_r - 18'h1;
                    if (tmr_r == 18'h1) begin
                        tmr_nxt = dur(fade_code_r, `STEP_BASE_TICKS);
                        if (scale_r == `SCALE_ZERO) begin
                            state_nxt = ST_SHDN;
                        end else begin
                            scale_nxt = scale_r - 3'h1;
                        end
                    end
                end
            end
            ST_SHDN: begin
                scale_nxt = `SCALE_ZERO;
                if (up_req) begin
                    state_nxt = ST_RAMP;
                    tmr_nxt   = dur(rise_code_r, `STEP_BASE_TICKS);
                    if (rise_code_r == 3'h0) begin
                        state_nxt = ST_RUN;
                        scale_nxt = `SCALE_FULL;
                    end
                end
            end
            ST_RAMP: begin
                if (PWM_TICK) begin
                    tmr_nxt = tmr_r - 18'h1;
                    if (tmr_r == 18'h1) begin
                        tmr_nxt = dur(rise_code_r, `STEP_BASE_TICKS);
                        if (scale_r == `SCALE_FULL) begin
                            state_nxt = ST_RUN;
                        end else begin
                            scale_nxt = scale_r + 3'h1;
                        end
                    end
                end
            end
            default: begin
                state_nxt = ST_RUN;
                scale_nxt = `SCALE_FULL;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_r <= ST_RUN;
            tmr_r   <= '0;
            scale_r <= `SCALE_FULL;
        end else begin
            state_r <= state_nxt;
            tmr_r   <= tmr_nxt;
            scale_r <= scale_nxt;
        end
    end

    // per-port control word {global code, full select}, all registered
    logic [9:0] full_sel;
    assign full_sel = {port_select_bits_high_r, port_select_bits_low_r};
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi++) begin : g_port
            always_ff @(posedge MCLK) begin
                if (RST) begin
                    PORT_CTRL[4*gi+3:4*gi] <= {`RST_GLOBAL, 1'b0};
                end else begin
                    PORT_CTRL[4*gi+3:4*gi] <= {global_r, full_sel[gi]};
                end
            end
        end
    endgenerate

    // master scale and shutdown flag to the analog reference
    always_ff @(posedge MCLK) begin
        if (RST) begin
            FADE_SCALE <= `SCALE_FULL;
            SHUTDOWN   <= 1'b0;
        end else begin
            FADE_SCALE <= scale_r;
            SHUTDOWN   <= state_r == ST_SHDN;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    sequence s_low_write;
        wr_stb && addr == `ADDR_SEL_LOW;
    endsequence
    sequence s_down_start;
        down_req;
    endsequence
    sequence s_fade_step;
        state_r == ST_FADE && PWM_TICK && tmr_r == 18'h1
            && scale_r != `SCALE_ZERO;
    endsequence

    a_low_select: assert property (s_low_write |-> ##2
        PORT_CTRL[0] == $past(wdata[0], 2)
        && PORT_CTRL[28] == $past(wdata[7], 2))
        else $error("low select byte not applied");
    a_high_select: assert property (wr_stb && addr == `ADDR_SEL_HIGH
        |=> port_select_bits_high_r == $past(wdata[1:0]))
        else $error("high select bits not stored");
    a_high_zero: assert property (addr == `ADDR_SEL_HIGH
        |-> rdata[7:2] == 6'h00)
        else $error("high select upper bits not zero");
    a_global_zero: assert property (addr == `ADDR_GLOBAL
        |-> rdata[7:3] == 5'h00 && rdata[2:0] == global_r)
        else $error("global register read wrong");
    a_global_reset: assert property (disable iff (1'b0)
        RST |=> global_r == 3'h7)
        else $error("global code not maximum after reset");
    a_code_follow: assert property (##1 PORT_CTRL[39:37] ==
        $past(global_r) && PORT_CTRL[3:1] == $past(global_r))
        else $error("port code differs from global code");
    a_other_port: assert property (s_low_write ##0 wdata[0] ==
        port_select_bits_low_r[0] |-> ##2 PORT_CTRL[0] == $past(PORT_CTRL[0]))
        else $error("untouched port disturbed");
    a_hold_len: assert property (s_down_start |=>
        state_r == ST_HOLD && tmr_r == dur($past(hold_code_r), `BASE_TICKS))
        else $error("hold-off length wrong");
    a_hold_full: assert property (state_r == ST_HOLD
        |-> scale_r == `SCALE_FULL ##1 FADE_SCALE == `SCALE_FULL)
        else $error("current reduced during hold-off");
    a_fade_step: assert property (s_fade_step |=>
        scale_r == $past(scale_r) - 3'h1 ##1 FADE_SCALE == $past(scale_r))
        else $error("fade step not taken");
    a_shdn_entry: assert property (state_r == ST_FADE ##1
        state_r == ST_SHDN |-> scale_r == `SCALE_ZERO ##1 SHUTDOWN)
        else $error("shutdown entered before fade done");
    a_ramp_done: assert property (state_r == ST_SHDN && up_req
        && rise_code_r == 3'h0 |=> state_r == ST_RUN
        && scale_r == `SCALE_FULL)
        else $error("instant ramp-up failed");
endmodule

// >>> verification/host_model.sv
`timescale 1ns/1ns
// host side of the serial link; sclk stands low outside frames
module host_model (
    input  wire logic clk,
    input  wire logic dout,
    output logic      cs_n,
    output logic      sclk,
    output logic      din
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din  = 1'b0;
    end

    // one 16-bit frame, msb first; read data comes back in the low byte
    task automatic xfer(input logic rd, input logic [6:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f;
        f = {rd, a, d};
        q = 8'h00;
        @(posedge clk);
        #1 cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            din = f[i];
            repeat (3) @(posedge clk);
            #1 sclk = 1'b1;
            repeat (3) @(posedge clk);
            #1;
            // read byte stands from the ninth rise to the sixteenth
            if (i <= 7)
                q = {q[6:0], dout};
            sclk = 1'b0;
        end
        repeat (3) @(posedge clk);
        #1 cs_n = 1'b1;
        din = ~din; // released data line shows the inverse, not a held bit
        repeat (4) @(posedge clk);
    endtask
endmodule

// >>> verification/testbench.sv
`timescale 1ns/1ns
module testbench;
    import led_pkg::*;
    logic        MCLK     = 1'b0;
    logic        RST      = 1'b1;
    logic        PWM_TICK = 1'b0;
    logic        CS_N;
    logic        SCLK;
    logic        DIN;
    logic        DOUT;
    logic [39:0] PORT_CTRL;
    logic [2:0]  FADE_SCALE;
    logic        SHUTDOWN;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cycles      = 0;
    int          steps;
    int          bad;
    logic [7:0]  rq;

    led_current_select_regs i_led_current_select_regs (
        .MCLK(MCLK), .RST(RST), .CS_N(CS_N), .SCLK(SCLK), .DIN(DIN),
        .PWM_TICK(PWM_TICK), .DOUT(DOUT), .PORT_CTRL(PORT_CTRL),
        .FADE_SCALE(FADE_SCALE), .SHUTDOWN(SHUTDOWN));

    host_model host (.clk(MCLK), .dout(DOUT), .cs_n(CS_N), .sclk(SCLK),
                     .din(DIN));

    always #20 MCLK = ~MCLK;

    // cut a hang short
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic close_out();
        $display("counts: %0d comparisons, %0d miscompares",
                 comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [39:0] seen, input logic [39:0] exp,
                       input string msg);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask

    // expected control word: per port {global code, full select}
    function automatic logic [39:0] cw(logic [9:0] sel, logic [2:0] g);
        logic [39:0] r;
        for (int i = 0; i < 10; i++)
            r[4*i +: 4] = {g, sel[i]};
        return r;
    endfunction

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d, rq);
        repeat (4) @(posedge MCLK);
        #2;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        host.xfer(1'b1, a, 8'h00, rq);
        chk({32'h0, rq}, {32'h0, e}, "read back");
    endtask

    // follow a ramp, counting single steps of the scale in one direction
    task automatic watch(input logic sd, input int lim);
        int n;
        logic [2:0] p;
        logic [2:0] nx;
        steps = 0;
        bad = 0;
        n = 0;
        p = FADE_SCALE;
        while (n < lim && (sd ? SHUTDOWN !== 1'b1 : FADE_SCALE !== 3'h7))
        begin
            @(posedge MCLK);
            #2;
            n++;
            nx = sd ? p - 3'h1 : p + 3'h1;
            if (FADE_SCALE !== p) begin
                if (FADE_SCALE === nx)
                    steps++;
                else
                    bad++;
                p = FADE_SCALE;
            end
        end
    endtask

    initial begin
        repeat (4) @(posedge MCLK);
        #1 RST = 1'b0;
        PWM_TICK = 1'b1;
        #2;
        chk(PORT_CTRL, 40'hEEEEEEEEEE, "ctrl reset");
        chk({37'h0, FADE_SCALE}, 40'h7, "scale reset");
        chk({39'h0, SHUTDOWN}, 40'h0, "shutdown reset");
        rd(7'h15, 8'h07);
        rd(7'h13, 8'h00);
        rd(7'h14, 8'h00);
        $display("test reset done");
        wr(7'h13, 8'hA5);
        rd(7'h13, 8'hA5);
        wr(7'h14, 8'hFE);
        rd(7'h14, 8'h02);
        chk(PORT_CTRL, cw(10'h2A5, 3'h7), "ctrl selects");
        for (int g = 0; g < 8; g++) begin
            wr(7'h15, {5'h1F, g[2:0]});
            rd(7'h15, {5'h00, g[2:0]});
            chk(PORT_CTRL, cw(10'h2A5, g[2:0]), "ctrl code");
        end
        wr(7'h13, 8'h5A);
        chk(PORT_CTRL, cw(10'h25A, 3'h7), "ctrl reselect");
        wr(7'h13, 8'hDA);
        chk(PORT_CTRL, cw(10'h2DA, 3'h7), "ctrl one port");
        wr(7'h13, 8'h5A);
        wr(7'h20, 8'hFF);
        rd(7'h20, 8'h00);
        chk(PORT_CTRL, cw(10'h25A, 3'h7), "ctrl unmapped");
        $display("test registers done");
        wr(7'h11, 8'h09);
        rd(7'h11, 8'h09);
        wr(7'h12, 8'hF9);
        rd(7'h12, 8'h01);
        wr(7'h10, 8'h00);
        repeat (1000) @(posedge MCLK);
        #2;
        chk({37'h0, FADE_SCALE}, 40'h7, "scale in hold");
        watch(1'b1, 5000);
        chk(40'(steps), 40'h7, "fade steps");
        chk(40'(bad), 40'h0, "fade jumps");
        chk({37'h0, FADE_SCALE}, 40'h0, "scale off");
        wr(7'h10, 8'h01);
        watch(1'b0, 5000);
        chk(40'(steps), 40'h7, "ramp steps");
        chk(40'(bad), 40'h0, "ramp jumps");
        repeat (300) @(posedge MCLK);
        #2;
        chk({39'h0, SHUTDOWN}, 40'h0, "awake");
        chk(PORT_CTRL, cw(10'h25A, 3'h7), "ctrl after ramps");
        $display("test coded ramps done");
        PWM_TICK = 1'b0;
        wr(7'h11, 8'h08);
        wr(7'h10, 8'h00);
        repeat (3000) @(posedge MCLK);
        #2;
        chk({39'h0, SHUTDOWN}, 40'h0, "no ticks no progress");
        rd(7'h10, 8'h09);
        PWM_TICK = 1'b1;
        watch(1'b1, 3000);
        chk({39'h0, SHUTDOWN}, 40'h1, "hold then off");
        rd(7'h10, 8'h00);
        wr(7'h12, 8'h00);
        wr(7'h10, 8'h01);
        watch(1'b0, 50);
        chk({37'h0, FADE_SCALE}, 40'h7, "instant full");
        chk({39'h0, SHUTDOWN}, 40'h0, "instant run");
        wr(7'h11, 8'h00);
        wr(7'h10, 8'h00);
        watch(1'b1, 50);
        chk({39'h0, SHUTDOWN}, 40'h1, "instant off");
        $display("test tick and instant ramps done");
        close_out();
    end
endmodule
